//--- core/oac_ctrl.v
// Overview of operation
// - circle diameter 0..100 percent of picture height, step one.
// - circle horizontal offset -50..+50 percent of width, step one.
// - circle vertical offset -50..+50 percent of height, step one.
// - circle diameter, circle offsets and logo position accept min, max or default keyword.
// - channel tone level -60..0 dBFS in 1 dB steps.
// - audio settings kept apart for main (1) and auxiliary (2) outputs.
// - sixteen audio channels, indexed one to sixteen.
// - tone frequency only from the listed set, others rejected.
// - frequency -1 stops audio data of that channel.
// - click every 1..4 seconds, none when set to zero.
// - tone silenced for a quarter second total around each click.
// - four audio groups switched on or off independently.
// - emphasis choice written to status bits only, samples untouched.
// - samples of 20 or 24 bits, chosen per group.
// - per-group sampling alignment code in status bits.
// - logo overlay on or off, one meaning on and zero off.
// - logo position -100..0 percent, tenth-percent steps.
// - logo image picked by selected logo number.
// - every setting has a query returning the value in effect.
// - circle overlay on or off by one setting.
`include "oac_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module oac_ctrl #(
	parameter SEC_CYC = `OAC_SEC_NS / `OAC_CLK_NS,
	parameter MUTE_HALF_CYC = `OAC_MUTE_NS / 2 / `OAC_CLK_NS,
	parameter LOGO_W = 4
) (
	input wire clk,
	input wire rst_n,
	input wire field_start,
	input wire cmd_valid,
	input wire cmd_write,
	input wire [3:0] cmd_sel,
	input wire [1:0] cmd_out,
	input wire [4:0] cmd_index,
	input wire [1:0] cmd_kw,
	input wire signed [15:0] cmd_value,
	output reg cmd_ready_reg,
	output reg rsp_valid_reg,
	output reg rsp_ok_reg,
	output reg signed [15:0] rsp_value_reg,
	output reg circ_on_reg,
	output reg [6:0] circ_diam_reg,
	output reg signed [6:0] circ_h_reg,
	output reg signed [6:0] circ_v_reg,
	output reg logo_on_reg,
	output reg signed [10:0] logo_h_reg,
	output reg signed [10:0] logo_v_reg,
	output reg [LOGO_W-1:0] logo_pick_reg,
	input wire aud_out,
	input wire [3:0] aud_ch,
	input wire [23:0] aud_sample,
	output reg aud_emit_reg,
	output reg signed [6:0] aud_level_reg,
	output reg signed [15:0] aud_freq_reg,
	output reg aud_mute_reg,
	output reg aud_click_reg,
	output reg [23:0] aud_data_reg,
	output reg grp_on_reg,
	output reg [1:0] grp_emph_reg,
	output reg grp_width24_reg,
	output reg [1:0] grp_sync_reg
);

	// full-width copies of the reset defaults, sliced to each register's width
	localparam signed [15:0] DIAM_DEF_W = `OAC_DIAM_DEF;
	localparam signed [15:0] CPOS_DEF_W = `OAC_CPOS_DEF;
	localparam signed [15:0] LPOS_DEF_W = `OAC_LPOS_DEF;
	localparam signed [15:0] LEVEL_DEF_W = `OAC_LEVEL_DEF;

	reg rst_meta_reg;
	reg rst_sync_reg;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	function freq_legal;
		input signed [15:0] f;
		begin
			case (f)
			-16'sd1, 16'sd0, 16'sd50, 16'sd100, 16'sd150, 16'sd200, 16'sd250,
			16'sd300, 16'sd400, 16'sd500, 16'sd600, 16'sd750, 16'sd800,
			16'sd1000, 16'sd1200, 16'sd1500, 16'sd1600, 16'sd2000, 16'sd2400,
			16'sd3000, 16'sd3200, 16'sd4000, 16'sd4800, 16'sd5000, 16'sd6000,
			16'sd8000, 16'sd9600, 16'sd10000, 16'sd12000, 16'sd15000,
			16'sd16000, 16'sd20000: freq_legal = 1'b1;
			default: freq_legal = 1'b0;
			endcase
		end
	endfunction

	function signed [15:0] kw_pick;
		input [1:0] kw;
		input signed [15:0] v;
		input signed [15:0] lo;
		input signed [15:0] hi;
		input signed [15:0] dflt;
		begin
			case (kw)
			`OAC_KW_MIN: kw_pick = lo;
			`OAC_KW_MAX: kw_pick = hi;
			`OAC_KW_DEF: kw_pick = dflt;
			default: kw_pick = v;
			endcase
		end
	endfunction

	// audio tables, indexed by {output, channel} and {output, group}
	reg signed [6:0] lvl_mem [0:31];
	reg signed [15:0] freq_mem [0:31];
	reg [2:0] click_mem [0:31];
	reg grp_on_mem [0:7];
	reg [1:0] emph_mem [0:7];
	reg w24_mem [0:7];
	reg [1:0] sync_mem [0:7];

	wire [4:0] ch_addr = {~cmd_out[0], cmd_index[3:0] - 4'h1};
	wire [2:0] grp_addr = {~cmd_out[0], cmd_index[1:0] - 2'h1};
	wire is_chan = (cmd_sel == `OAC_SEL_CH_LEVEL) || (cmd_sel == `OAC_SEL_CH_FREQ) ||
		(cmd_sel == `OAC_SEL_CH_CLICK);
	wire is_grp = (cmd_sel == `OAC_SEL_GRP_EN) || (cmd_sel == `OAC_SEL_GRP_EMPH) ||
		(cmd_sel == `OAC_SEL_GRP_WIDTH) || (cmd_sel == `OAC_SEL_GRP_SYNC);
	wire out_ok = (cmd_out == 2'h1) || (cmd_out == 2'h2);
	wire ch_ok = (cmd_index >= 5'h01) && (cmd_index <= 5'h10);
	wire grp_ok = (cmd_index >= 5'h01) && (cmd_index <= 5'h04);

	reg signed [15:0] eff_val;
	reg range_ok;
	reg signed [15:0] q_val;
	always @* begin
		eff_val = cmd_value;
		range_ok = 1'b0;
		q_val = 16'sh0000;
		case (cmd_sel)
		`OAC_SEL_CIRC_EN: begin
			range_ok = (cmd_kw == `OAC_KW_NUM) && (cmd_value[15:1] == 15'h0000);
			q_val = {15'h0000, circ_on_reg};
		end
		`OAC_SEL_CIRC_DIAM: begin
			eff_val = kw_pick(cmd_kw, cmd_value, `OAC_DIAM_MIN, `OAC_DIAM_MAX,
				`OAC_DIAM_DEF);
			range_ok = (eff_val >= `OAC_DIAM_MIN) && (eff_val <= `OAC_DIAM_MAX);
			q_val = {9'h000, circ_diam_reg};
		end
		`OAC_SEL_CIRC_H, `OAC_SEL_CIRC_V: begin
			eff_val = kw_pick(cmd_kw, cmd_value, `OAC_CPOS_MIN, `OAC_CPOS_MAX,
				`OAC_CPOS_DEF);
			range_ok = (eff_val >= `OAC_CPOS_MIN) && (eff_val <= `OAC_CPOS_MAX);
			q_val = (cmd_sel == `OAC_SEL_CIRC_H) ? {{9{circ_h_reg[6]}}, circ_h_reg} :
				{{9{circ_v_reg[6]}}, circ_v_reg};
		end
		`OAC_SEL_LOGO_EN: begin
			range_ok = (cmd_kw == `OAC_KW_NUM) && (cmd_value[15:1] == 15'h0000);
			q_val = {15'h0000, logo_on_reg};
		end
		`OAC_SEL_LOGO_H, `OAC_SEL_LOGO_V: begin
			eff_val = kw_pick(cmd_kw, cmd_value, `OAC_LPOS_MIN, `OAC_LPOS_MAX,
				`OAC_LPOS_DEF);
			range_ok = (eff_val >= `OAC_LPOS_MIN) && (eff_val <= `OAC_LPOS_MAX);
			q_val = (cmd_sel == `OAC_SEL_LOGO_H) ? {{5{logo_h_reg[10]}}, logo_h_reg} :
				{{5{logo_v_reg[10]}}, logo_v_reg};
		end
		`OAC_SEL_LOGO_PICK: begin
			range_ok = (cmd_kw == `OAC_KW_NUM) && (cmd_value >= 16'sh0000) &&
				(cmd_value < (16'sh0001 <<< LOGO_W));
			q_val = {{(16-LOGO_W){1'b0}}, logo_pick_reg};
		end
		`OAC_SEL_CH_LEVEL: begin
			range_ok = (cmd_kw == `OAC_KW_NUM) && (cmd_value >= `OAC_LEVEL_MIN) &&
				(cmd_value <= `OAC_LEVEL_MAX);
			q_val = {{9{lvl_mem[ch_addr][6]}}, lvl_mem[ch_addr]};
		end
		`OAC_SEL_CH_FREQ: begin
			range_ok = (cmd_kw == `OAC_KW_NUM) && freq_legal(cmd_value);
			q_val = freq_mem[ch_addr];
		end
		`OAC_SEL_CH_CLICK: begin
			range_ok = (cmd_kw == `OAC_KW_NUM) && (cmd_value >= 16'sh0000) &&
				(cmd_value <= `OAC_CLICK_MAX);
			q_val = {13'h0000, click_mem[ch_addr]};
		end
		`OAC_SEL_GRP_EN: begin
			range_ok = (cmd_kw == `OAC_KW_NUM) && (cmd_value[15:1] == 15'h0000);
			q_val = {15'h0000, grp_on_mem[grp_addr]};
		end
		`OAC_SEL_GRP_EMPH, `OAC_SEL_GRP_SYNC: begin
			range_ok = (cmd_kw == `OAC_KW_NUM) && (cmd_value >= 16'sh0000) &&
				(cmd_value <= `OAC_CODE3_MAX);
			q_val = (cmd_sel == `OAC_SEL_GRP_EMPH) ? {14'h0000, emph_mem[grp_addr]} :
				{14'h0000, sync_mem[grp_addr]};
		end
		`OAC_SEL_GRP_WIDTH: begin
			range_ok = (cmd_kw == `OAC_KW_NUM) &&
				((cmd_value == `OAC_WIDTH_20) || (cmd_value == `OAC_WIDTH_24));
			q_val = w24_mem[grp_addr] ? `OAC_WIDTH_24 : `OAC_WIDTH_20;
		end
		default: begin
			range_ok = 1'b0;
			q_val = 16'sh0000;
		end
		endcase
	end

	wire idx_ok = (is_chan ? (out_ok && ch_ok) : 1'b1) && (is_grp ? (out_ok && grp_ok) : 1'b1);
	wire cmd_ok = idx_ok && (!cmd_write || range_ok);
	wire take = cmd_valid && cmd_ready_reg;

	// one write waits here until the next field boundary
	reg pend_reg;
	reg [3:0] pend_sel_reg;
	reg [4:0] pend_ch_reg;
	reg [2:0] pend_grp_reg;
	reg signed [15:0] pend_val_reg;
	wire commit = pend_reg && field_start;

	always @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			cmd_ready_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_ok_reg <= 1'b0;
			rsp_value_reg <= 16'sh0000;
			pend_reg <= 1'b0;
			pend_sel_reg <= 4'h0;
			pend_ch_reg <= 5'h00;
			pend_grp_reg <= 3'h0;
			pend_val_reg <= 16'sh0000;
		end else begin
			rsp_valid_reg <= take;
			if (take) begin
				rsp_ok_reg <= cmd_ok;
				rsp_value_reg <= (cmd_write || !cmd_ok) ? 16'sh0000 : q_val;
			end
			if (take && cmd_write && cmd_ok) begin
				pend_reg <= 1'b1;
				pend_sel_reg <= cmd_sel;
				pend_ch_reg <= ch_addr;
				pend_grp_reg <= grp_addr;
				pend_val_reg <= eff_val;
			end else if (commit) begin
				pend_reg <= 1'b0;
			end
			cmd_ready_reg <= !(pend_reg && !commit) && !(take && cmd_write && cmd_ok);
		end
	end

	always @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			circ_on_reg <= 1'b0;
			circ_diam_reg <= DIAM_DEF_W[6:0];
			circ_h_reg <= CPOS_DEF_W[6:0];
			circ_v_reg <= CPOS_DEF_W[6:0];
			logo_on_reg <= 1'b0;
			logo_h_reg <= LPOS_DEF_W[10:0];
			logo_v_reg <= LPOS_DEF_W[10:0];
			logo_pick_reg <= {LOGO_W{1'b0}};
		end else if (commit) begin
			case (pend_sel_reg)
			`OAC_SEL_CIRC_EN: circ_on_reg <= pend_val_reg[0];
			`OAC_SEL_CIRC_DIAM: circ_diam_reg <= pend_val_reg[6:0];
			`OAC_SEL_CIRC_H: circ_h_reg <= pend_val_reg[6:0];
			`OAC_SEL_CIRC_V: circ_v_reg <= pend_val_reg[6:0];
			`OAC_SEL_LOGO_EN: logo_on_reg <= pend_val_reg[0];
			`OAC_SEL_LOGO_H: logo_h_reg <= pend_val_reg[10:0];
			`OAC_SEL_LOGO_V: logo_v_reg <= pend_val_reg[10:0];
			`OAC_SEL_LOGO_PICK: logo_pick_reg <= pend_val_reg[LOGO_W-1:0];
			default: ;
			endcase
		end
	end

	integer i;
	always @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			for (i = 0; i < 32; i = i + 1) begin
				lvl_mem[i] <= LEVEL_DEF_W[6:0];
				freq_mem[i] <= `OAC_FREQ_DEF;
				click_mem[i] <= 3'h0;
			end
			for (i = 0; i < 8; i = i + 1) begin
				grp_on_mem[i] <= 1'b1;
				emph_mem[i] <= `OAC_EMPH_NONE;
				w24_mem[i] <= 1'b0;
				sync_mem[i] <= `OAC_SYNC_FRAME;
			end
		end else if (commit) begin
			case (pend_sel_reg)
			`OAC_SEL_CH_LEVEL: lvl_mem[pend_ch_reg] <= pend_val_reg[6:0];
			`OAC_SEL_CH_FREQ: freq_mem[pend_ch_reg] <= pend_val_reg;
			`OAC_SEL_CH_CLICK: click_mem[pend_ch_reg] <= pend_val_reg[2:0];
			`OAC_SEL_GRP_EN: grp_on_mem[pend_grp_reg] <= pend_val_reg[0];
			`OAC_SEL_GRP_EMPH: emph_mem[pend_grp_reg] <= pend_val_reg[1:0];
			`OAC_SEL_GRP_WIDTH: w24_mem[pend_grp_reg] <= (pend_val_reg == `OAC_WIDTH_24);
			`OAC_SEL_GRP_SYNC: sync_mem[pend_grp_reg] <= pend_val_reg[1:0];
			default: ;
			endcase
		end
	end

	// shared one-second time base; seconds count modulo 12 serves periods 1..4
	reg [31:0] frac_reg;
	reg [3:0] sec_reg;
	always @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			frac_reg <= 32'h00000000;
			sec_reg <= 4'h0;
		end else if (frac_reg == SEC_CYC - 1) begin
			frac_reg <= 32'h00000000;
			sec_reg <= (sec_reg == `OAC_CLICK_CYCLE - 4'h1) ? 4'h0 : sec_reg + 4'h1;
		end else begin
			frac_reg <= frac_reg + 32'h00000001;
		end
	end

	function sec_hit;
		input [3:0] s;
		input [2:0] n;
		begin
			sec_hit = (n != 3'h0) && ((s % {1'b0, n}) == 4'h0);
		end
	endfunction

	wire [4:0] rd_addr = {aud_out, aud_ch};
	wire [2:0] rd_grp = {aud_out, aud_ch[3:2]};
	wire [2:0] rd_click = click_mem[rd_addr];
	wire [3:0] sec_nx = (sec_reg == `OAC_CLICK_CYCLE - 4'h1) ? 4'h0 : sec_reg + 4'h1;
	wire near_after = (frac_reg < MUTE_HALF_CYC) && sec_hit(sec_reg, rd_click);
	wire near_before = (frac_reg >= SEC_CYC - MUTE_HALF_CYC) && sec_hit(sec_nx, rd_click);

	always @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			aud_emit_reg <= 1'b0;
			aud_level_reg <= 7'sh00;
			aud_freq_reg <= 16'sh0000;
			aud_mute_reg <= 1'b0;
			aud_click_reg <= 1'b0;
			aud_data_reg <= 24'h000000;
			grp_on_reg <= 1'b0;
			grp_emph_reg <= 2'h0;
			grp_width24_reg <= 1'b0;
			grp_sync_reg <= 2'h0;
		end else begin
			aud_emit_reg <= grp_on_mem[rd_grp] &&
				(freq_mem[rd_addr] != `OAC_FREQ_OFF);
			aud_level_reg <= lvl_mem[rd_addr];
			aud_freq_reg <= freq_mem[rd_addr];
			aud_mute_reg <= near_after || near_before;
			aud_click_reg <= (frac_reg == 32'h00000000) && sec_hit(sec_reg, rd_click);
			aud_data_reg <= w24_mem[rd_grp] ? aud_sample :
				{aud_sample[23:4], 4'h0};
			grp_on_reg <= grp_on_mem[rd_grp];
			grp_emph_reg <= emph_mem[rd_grp];
			grp_width24_reg <= w24_mem[rd_grp];
			grp_sync_reg <= sync_mem[rd_grp];
		end
	end

endmodule

`default_nettype wire

//--- core/oac_defs.vh
`ifndef OAC_DEFS_VH
`define OAC_DEFS_VH

// setting selectors carried on cmd_sel
`define OAC_SEL_CIRC_EN 4'h0
`define OAC_SEL_CIRC_DIAM 4'h1
`define OAC_SEL_CIRC_H 4'h2
`define OAC_SEL_CIRC_V 4'h3
`define OAC_SEL_LOGO_EN 4'h4
`define OAC_SEL_LOGO_H 4'h5
`define OAC_SEL_LOGO_V 4'h6
`define OAC_SEL_LOGO_PICK 4'h7
`define OAC_SEL_CH_LEVEL 4'h8
`define OAC_SEL_CH_FREQ 4'h9
`define OAC_SEL_CH_CLICK 4'ha
`define OAC_SEL_GRP_EN 4'hb
`define OAC_SEL_GRP_EMPH 4'hc
`define OAC_SEL_GRP_WIDTH 4'hd
`define OAC_SEL_GRP_SYNC 4'he

// value keywords carried on cmd_kw
`define OAC_KW_NUM 2'h0
`define OAC_KW_MIN 2'h1
`define OAC_KW_MAX 2'h2
`define OAC_KW_DEF 2'h3

// limits and defaults, signed 16-bit
`define OAC_DIAM_MIN 16'sh0000
`define OAC_DIAM_MAX 16'sh0064
`define OAC_DIAM_DEF 16'sh0032
`define OAC_CPOS_MIN (-16'sh0032)
`define OAC_CPOS_MAX 16'sh0032
`define OAC_CPOS_DEF 16'sh0000
`define OAC_LPOS_MIN (-16'sh03e8)
`define OAC_LPOS_MAX 16'sh0000
`define OAC_LPOS_DEF 16'sh0000
`define OAC_LEVEL_MIN (-16'sh003c)
`define OAC_LEVEL_MAX 16'sh0000
`define OAC_LEVEL_DEF (-16'sh0014)
`define OAC_FREQ_OFF (-16'sh0001)
`define OAC_FREQ_DEF 16'sh03e8
`define OAC_CLICK_MAX 16'sh0004
`define OAC_WIDTH_20 16'sh0014
`define OAC_WIDTH_24 16'sh0018
`define OAC_CODE3_MAX 16'sh0002

// emphasis and sampling alignment codes
`define OAC_EMPH_NONE 2'h0
`define OAC_EMPH_DISC 2'h1
`define OAC_EMPH_TELECOM 2'h2
`define OAC_SYNC_FRAME 2'h0
`define OAC_SYNC_NOSEQ 2'h1
`define OAC_SYNC_FREE 2'h2

// timing
`define OAC_CLK_NS 20
`define OAC_SEC_NS 1000000000
`define OAC_MUTE_NS 250000000
`define OAC_CLICK_CYCLE 4'hc

`endif

//--- tb/oac_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module oac_ctrl_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic field_start,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic cmd_ready_reg,
	input wire logic rsp_valid_reg,
	input wire logic rsp_ok_reg,
	input wire logic [6:0] circ_diam_reg,
	input wire logic signed [6:0] circ_h_reg,
	input wire logic signed [10:0] logo_h_reg,
	input wire logic [23:0] aud_sample,
	input wire logic aud_emit_reg,
	input wire logic signed [15:0] aud_freq_reg,
	input wire logic aud_mute_reg,
	input wire logic aud_click_reg,
	input wire logic [23:0] aud_data_reg,
	input wire logic grp_on_reg,
	input wire logic grp_width24_reg
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_answer;
		cmd_valid && cmd_ready_reg |=> rsp_valid_reg;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after a taken command");
	property p_no_stray;
		rsp_valid_reg |-> $past(cmd_valid && cmd_ready_reg);
	endproperty
	a_no_stray: assert property (p_no_stray) else $error("answer without a command");
	property p_hold;
		rsp_valid_reg && rsp_ok_reg && $past(cmd_write) |-> !cmd_ready_reg;
	endproperty
	a_hold: assert property (p_hold) else $error("ready high with a write pending");
	property p_commit;
		$past(rst_n, 3) && field_start && !cmd_ready_reg |=> cmd_ready_reg;
	endproperty
	a_commit: assert property (p_commit) else $error("pending write not committed");
	property p_at_field;
		$changed(circ_diam_reg) || $changed(logo_h_reg) |-> $past(field_start);
	endproperty
	a_at_field: assert property (p_at_field) else $error("setting changed off a field");
	property p_ranges;
		circ_diam_reg <= 7'h64 && circ_h_reg >= -7'sh32 && circ_h_reg <= 7'sh32;
	endproperty
	a_ranges: assert property (p_ranges) else $error("circle setting out of range");
	property p_logo;
		logo_h_reg >= -11'sh3e8 && logo_h_reg <= 11'sh000;
	endproperty
	a_logo: assert property (p_logo) else $error("logo position out of range");
	property p_emit;
		aud_emit_reg |-> grp_on_reg && aud_freq_reg != -16'sh0001;
	endproperty
	a_emit: assert property (p_emit) else $error("audio emitted while disabled");
	property p_width;
		$past(rst_n, 3) && !grp_width24_reg |->
			aud_data_reg == {$past(aud_sample[23:4]), 4'h0};
	endproperty
	a_width: assert property (p_width) else $error("20-bit sample not truncated");
	property p_click;
		aud_click_reg |-> aud_mute_reg;
	endproperty
	a_click: assert property (p_click) else $error("click outside the mute window");
	c_click: cover property (aud_click_reg);
	c_reject: cover property (rsp_valid_reg && !rsp_ok_reg);
	c_commit: cover property (field_start && !cmd_ready_reg);
endmodule
bind oac_ctrl oac_ctrl_props i_oac_ctrl_props (.clk, .rst_n, .field_start, .cmd_valid,
	.cmd_write, .cmd_ready_reg, .rsp_valid_reg, .rsp_ok_reg, .circ_diam_reg, .circ_h_reg,
	.logo_h_reg, .aud_sample, .aud_emit_reg, .aud_freq_reg, .aud_mute_reg, .aud_click_reg,
	.aud_data_reg, .grp_on_reg, .grp_width24_reg);
`default_nettype wire

//--- tb/oac_video_sink.sv
`timescale 1ns/1ps
`default_nettype none
// far-side model: field timing and a sample stream that changes every cycle
module oac_video_sink (
	input wire logic clk,
	input wire logic rst_n,
	output logic field_start,
	output logic [23:0] aud_sample
);
	logic [3:0] fcnt_reg;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fcnt_reg <= 4'h0;
			field_start <= 1'b0;
			aud_sample <= 24'h5a3c96;
		end else begin
			fcnt_reg <= fcnt_reg + 4'h1;
			field_start <= (fcnt_reg == 4'hf);
			aud_sample <= aud_sample + 24'h3b5a7f;
		end
	end
endmodule
`default_nettype wire

//--- tb/oac_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "oac_defs.vh"
module oac_ctrl_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0, cmd_write = 1'b0, aud_out = 1'b0;
	logic [3:0] cmd_sel = 4'h0, aud_ch = 4'h0;
	logic [1:0] cmd_out = 2'h1, cmd_kw = 2'h0;
	logic [4:0] cmd_index = 5'h01;
	logic signed [15:0] cmd_value = 16'sh0000;
	logic field_start, cmd_ready_reg, rsp_valid_reg, rsp_ok_reg;
	logic aud_emit_reg, aud_mute_reg, aud_click_reg;
	logic signed [15:0] rsp_value_reg;
	logic [23:0] aud_sample, aud_data_reg;
	logic circ_on_reg, logo_on_reg, grp_on_reg, grp_width24_reg;
	logic [6:0] circ_diam_reg;
	logic signed [6:0] circ_h_reg, circ_v_reg, aud_level_reg;
	logic signed [10:0] logo_h_reg, logo_v_reg;
	logic [3:0] logo_pick_reg;
	logic signed [15:0] aud_freq_reg;
	logic [1:0] grp_emph_reg, grp_sync_reg;
	integer n_errors = 0, samples_checked = 0, cyc = 0, i;
	always #10 clk = ~clk;
	oac_video_sink i_oac_video_sink (.clk(clk), .rst_n(rst_n), .field_start(field_start),
		.aud_sample(aud_sample));
	oac_ctrl #(.SEC_CYC(200), .MUTE_HALF_CYC(25)) i_oac_ctrl (.clk(clk), .rst_n(rst_n),
		.field_start(field_start), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_sel(cmd_sel), .cmd_out(cmd_out), .cmd_index(cmd_index), .cmd_kw(cmd_kw),
		.cmd_value(cmd_value), .cmd_ready_reg(cmd_ready_reg), .rsp_valid_reg(rsp_valid_reg),
		.rsp_ok_reg(rsp_ok_reg), .rsp_value_reg(rsp_value_reg),
		.circ_on_reg(circ_on_reg), .circ_diam_reg(circ_diam_reg),
		.circ_h_reg(circ_h_reg), .circ_v_reg(circ_v_reg), .logo_on_reg(logo_on_reg),
		.logo_h_reg(logo_h_reg), .logo_v_reg(logo_v_reg), .logo_pick_reg(logo_pick_reg),
		.aud_out(aud_out), .aud_ch(aud_ch),
		.aud_sample(aud_sample), .aud_emit_reg(aud_emit_reg),
		.aud_level_reg(aud_level_reg), .aud_freq_reg(aud_freq_reg),
		.aud_mute_reg(aud_mute_reg), .aud_click_reg(aud_click_reg),
		.aud_data_reg(aud_data_reg), .grp_on_reg(grp_on_reg),
		.grp_emph_reg(grp_emph_reg), .grp_width24_reg(grp_width24_reg),
		.grp_sync_reg(grp_sync_reg));
	task finish_test;
		begin
			$display("checked %0d mismatches %0d", samples_checked, n_errors);
			if (n_errors == 0 && samples_checked > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			n_errors = n_errors + 1;
			finish_test;
		end
	end
	task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("FAIL %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task chk_n(input string nm, input integer lo, input integer hi, input integer g);
		logic ok;
		begin
			ok = (g >= lo && g <= hi);
			samples_checked = samples_checked + 1;
			if (ok !== 1'b1) begin
				n_errors = n_errors + 1;
				$display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
			end
		end
	endtask
	task cmd(input logic w, input logic [3:0] s, input logic [1:0] o, input logic [4:0] ix,
		input logic [1:0] k, input logic signed [15:0] v, input logic eok,
		input logic signed [15:0] ev);
		integer n;
		begin
			n = 0;
			@(posedge clk);
			{cmd_valid, cmd_write, cmd_sel, cmd_out, cmd_index, cmd_kw, cmd_value} <=
				{1'b1, w, s, o, ix, k, v};
			do begin
				@(posedge clk);
				n = n + 1;
			end while (cmd_ready_reg !== 1'b1 && n < 100);
			cmd_valid <= 1'b0;
			@(posedge clk);
			chk("rsp_valid", 24'h000001, 24'(rsp_valid_reg));
			chk("rsp_ok", 24'(eok), 24'(rsp_ok_reg));
			chk("rsp_value", 24'(ev), 24'(rsp_value_reg));
		end
	endtask
	// write (optional) then query; a bad channel or group index is refused either way
	task run(input logic w, input logic [3:0] s, input logic [1:0] o, input logic [4:0] ix,
		input logic [1:0] k, input logic signed [15:0] v, input logic eok,
		input logic signed [15:0] q);
		logic qok;
		begin
			qok = (s < 4'h8) || (ix >= 5'h01 && ix <= (s < 4'hb ? 5'h10 : 5'h04));
			if (w)
				cmd(1'b1, s, o, ix, k, v, eok, 16'sh0000);
			cmd(1'b0, s, o, ix, 2'h0, 16'sh0000, qok, qok ? q : 16'sh0000);
		end
	endtask
	task rd(input logic o, input logic [3:0] ch, input logic ee, input logic full);
		logic [23:0] smp;
		begin
			@(posedge clk);
			{aud_out, aud_ch} <= {o, ch};
			@(posedge clk);
			smp = aud_sample;
			@(posedge clk);
			chk("aud_emit", 24'(ee), 24'(aud_emit_reg));
			chk("aud_data", full ? smp : {smp[23:4], 4'h0}, aud_data_reg);
			chk("grp_width24", 24'(full), 24'(grp_width24_reg));
		end
	endtask
	task clicks(input logic [3:0] ch, input integer nc);
		integer j, nk, nm;
		begin
			nk = 0;
			nm = 0;
			@(posedge clk);
			{aud_out, aud_ch} <= {1'b0, ch};
			repeat (2) @(posedge clk);
			for (j = 0; j < 2400; j = j + 1) begin
				@(posedge clk);
				nk = nk + aud_click_reg;
				nm = nm + aud_mute_reg;
			end
			chk_n("clicks", nc, nc, nk);
			chk_n("muted", nc * 50, nc * 51, nm);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		run(0, `OAC_SEL_CIRC_DIAM, 2'h1, 5'h01, 2'h0, 16'sh0000, 1, 16'sh0032);
		run(1, `OAC_SEL_CIRC_DIAM, 2'h1, 5'h01, 2'h0, 16'sh0064, 1, 16'sh0064);
		run(1, `OAC_SEL_CIRC_DIAM, 2'h1, 5'h01, 2'h0, 16'sh0065, 0, 16'sh0064);
		for (i = 1; i < 4; i = i + 1)
			run(1, `OAC_SEL_CIRC_DIAM, 2'h1, 5'h01, 2'(i), 16'sh0000, 1, 16'((i - 1) * 100 % 150));
		run(1, `OAC_SEL_CIRC_H, 2'h1, 5'h01, 2'h0, -16'sh0032, 1, -16'sh0032);
		run(1, `OAC_SEL_CIRC_H, 2'h1, 5'h01, 2'h0, -16'sh0033, 0, -16'sh0032);
		run(1, `OAC_SEL_CIRC_V, 2'h1, 5'h01, 2'h2, 16'sh0000, 1, 16'sh0032);
		run(1, `OAC_SEL_CIRC_V, 2'h1, 5'h01, 2'h0, 16'sh0033, 0, 16'sh0032);
		run(1, `OAC_SEL_CIRC_EN, 2'h1, 5'h01, 2'h0, 16'sh0001, 1, 16'sh0001);
		run(1, `OAC_SEL_LOGO_EN, 2'h1, 5'h01, 2'h0, 16'sh0001, 1, 16'sh0001);
		run(1, `OAC_SEL_LOGO_H, 2'h1, 5'h01, 2'h0, -16'sh03e8, 1, -16'sh03e8);
		run(1, `OAC_SEL_LOGO_H, 2'h1, 5'h01, 2'h0, 16'sh0001, 0, -16'sh03e8);
		run(1, `OAC_SEL_LOGO_V, 2'h1, 5'h01, 2'h1, 16'sh0000, 1, -16'sh03e8);
		run(1, `OAC_SEL_LOGO_PICK, 2'h1, 5'h01, 2'h0, 16'sh0005, 1, 16'sh0005);
		run(1, `OAC_SEL_CH_LEVEL, 2'h1, 5'h10, 2'h0, -16'sh003c, 1, -16'sh003c);
		run(1, `OAC_SEL_CH_LEVEL, 2'h1, 5'h10, 2'h0, -16'sh003d, 0, -16'sh003c);
		run(0, `OAC_SEL_CH_LEVEL, 2'h2, 5'h10, 2'h0, 16'sh0000, 1, -16'sh0014);
		run(1, `OAC_SEL_CH_LEVEL, 2'h1, 5'h11, 2'h0, 16'sh0000, 0, 16'sh0000);
		run(1, `OAC_SEL_CH_LEVEL, 2'h1, 5'h01, 2'h2, 16'sh0000, 0, -16'sh0014);
		run(1, `OAC_SEL_CH_FREQ, 2'h1, 5'h02, 2'h0, 16'sh4e20, 1, 16'sh4e20);
		run(1, `OAC_SEL_CH_FREQ, 2'h1, 5'h02, 2'h0, 16'sh03e9, 0, 16'sh4e20);
		run(1, `OAC_SEL_CH_FREQ, 2'h1, 5'h01, 2'h0, -16'sh0001, 1, -16'sh0001);
		run(1, `OAC_SEL_CH_CLICK, 2'h1, 5'h03, 2'h0, 16'sh0001, 1, 16'sh0001);
		run(1, `OAC_SEL_CH_CLICK, 2'h1, 5'h04, 2'h0, 16'sh0004, 1, 16'sh0004);
		run(1, `OAC_SEL_CH_CLICK, 2'h1, 5'h04, 2'h0, 16'sh0005, 0, 16'sh0004);
		run(1, `OAC_SEL_GRP_EN, 2'h1, 5'h04, 2'h0, 16'sh0000, 1, 16'sh0000);
		run(1, `OAC_SEL_GRP_EN, 2'h1, 5'h05, 2'h0, 16'sh0000, 0, 16'sh0000);
		for (i = 0; i < 4; i = i + 1) begin
			run(1, `OAC_SEL_GRP_EMPH, 2'h1, 5'h01, 2'h0, 16'(i), i < 3, 16'(i < 3 ? i : 2));
			run(1, `OAC_SEL_GRP_SYNC, 2'h1, 5'h01, 2'h0, 16'(i), i < 3, 16'(i < 3 ? i : 2));
		end
		run(1, `OAC_SEL_GRP_WIDTH, 2'h1, 5'h02, 2'h0, 16'sh0018, 1, 16'sh0018);
		run(1, `OAC_SEL_GRP_WIDTH, 2'h1, 5'h02, 2'h0, 16'sh0016, 0, 16'sh0018);
		chk("circ_on", 24'h000001, 24'(circ_on_reg));
		chk("circ_diam", 24'(`OAC_DIAM_DEF), 24'(circ_diam_reg));
		chk("circ_h", 24'(-16'sh0032), 24'(circ_h_reg));
		chk("circ_v", 24'(`OAC_CPOS_MAX), 24'(circ_v_reg));
		chk("logo_on", 24'h000001, 24'(logo_on_reg));
		chk("logo_h", 24'(`OAC_LPOS_MIN), 24'(logo_h_reg));
		chk("logo_v", 24'(`OAC_LPOS_MIN), 24'(logo_v_reg));
		chk("logo_pick", 24'h000005, 24'(logo_pick_reg));
		$display("settings test done");
		rd(1'b0, 4'h0, 1'b0, 1'b0);
		chk("aud_freq", 24'(-16'sh0001), 24'(aud_freq_reg));
		chk("aud_level", 24'(`OAC_LEVEL_DEF), 24'(aud_level_reg));
		chk("grp_emph", 24'(`OAC_EMPH_TELECOM), 24'(grp_emph_reg));
		chk("grp_sync", 24'(`OAC_SYNC_FREE), 24'(grp_sync_reg));
		rd(1'b0, 4'h1, 1'b1, 1'b0);
		rd(1'b0, 4'hc, 1'b0, 1'b0);
		chk("grp_on", 24'h000000, 24'(grp_on_reg));
		rd(1'b0, 4'h4, 1'b1, 1'b1);
		rd(1'b1, 4'h0, 1'b1, 1'b0);
		$display("audio read test done");
		clicks(4'h2, 12);
		clicks(4'h3, 3);
		clicks(4'h4, 0);
		$display("click test done");
		finish_test;
	end
endmodule
`default_nettype wire
